// >>> verilog/asfs_top.sv
// converter sample formatter, fractional clock divider and serializer
//
// Summary of operation
// - samples coded as offset binary, sign-magnitude or two's complement
// - sign-magnitude: sign 0 positive, magnitude codes per level
// - offset binary: +7 all ones down to -7 all zeros
// - two's complement: positive 0xx, negative 1 with inverted magnitude
// - after reset both channels give 2-bit sign and magnitude
// - resolutions: 1 or 2 bits on I and Q, or 1..3 bits I only
// - msb on the upper pin, lsb on the lower pin of a channel
// - 3-bit I only: msb I upper, middle I lower, lsb Q upper
// - converter rate derived from reference by 12-bit fractional divider
// - divider alternates adjacent integer ratios to reach the fraction
// - rate ratio is low over (4096 minus modulo plus low)
// - lanes 0,1 carry I and lanes 2,3 carry Q
// - 16-bit segments sent lane 0 first, then enabled higher lanes
// - lane select picks lane 0, lanes 0+1, lanes 0+2 or all four
// - lane 0 only gives back to back lane 0 segments
// - two lanes give lane 0 segment then second lane segment
// - serial rate must be 1x, 2x or 4x converter rate per lane count
// - converter bits collect in four 16-bit holding registers
// - full slice moves to shift registers, shifted during next slice
// - zeros on serial output once a slice is fully sent
// - slice start strobe marks the first bit of each slice
// - timing strobe every 128 to 16384 converter cycles
// - stream register sets how many slices are sent before stopping
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module asfs_top
    import asfs_pkg::*;
#(
    parameter logic [11:0] LOW_RST    = 12'h100,
    parameter logic [11:0] MOD_RST    = 12'hE00,
    parameter logic [7:0]  SERDIV_RST = 8'h00
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rdata,
    input  wire asfs_lvl_t         quant_i,
    input  wire asfs_lvl_t         quant_q,
    output logic                   inphase_upper_pin,
    output logic                   inphase_lower_pin,
    output logic                   quadrature_upper_pin,
    output logic                   quadrature_lower_pin,
    output logic                   conv_strobe,
    output logic                   serial_strobe,
    output logic                   serial_data,
    output logic                   slice_start_strobe,
    output logic                   time_strobe
);

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    // 3-bit code of one level; narrower codes use the top bits
    function automatic logic [2:0] encode(asfs_fmt_t f, asfs_lvl_t l);
        logic [1:0] low;
        low = (f != FMT_SIGNMAG && l.neg) ? ~l.mag : l.mag;
        case (f)
            FMT_OFFSET: encode = {~l.neg, low};
            FMT_TWOS:   encode = {l.neg, low};
            default:    encode = {l.neg, low};
        endcase
    endfunction : encode

    // pin bits {i upper, i lower, q upper, q lower}
    function automatic logic [3:0] pin_map(asfs_cfg_t c, asfs_lvl_t i,
                                           asfs_lvl_t q);
        logic [2:0] ei;
        logic [2:0] eq;
        ei = encode(c.fmt, i);
        eq = encode(c.fmt, q);
        case (c.res)
            RES_IQ1: pin_map = {ei[2], 1'b0, eq[2], 1'b0};
            RES_I1:  pin_map = {ei[2], 3'b000};
            RES_I2:  pin_map = {ei[2], ei[1], 2'b00};
            RES_I3:  pin_map = {ei[2], ei[1], ei[0], 1'b0};
            default: pin_map = {ei[2], ei[1], eq[2], eq[1]};
        endcase
    endfunction : pin_map

    // lane carried by segment number s of the selected set
    function automatic logic [1:0] lane_of(asfs_lanes_t sel,
                                           logic [1:0] s);
        case (sel)
            LANES_01: lane_of = {1'b0, s[0]};
            LANES_02: lane_of = {s[0], 1'b0};
            LANES_ALL: lane_of = s;
            default:  lane_of = 2'h0;
        endcase
    endfunction : lane_of

    // bits in one serial frame for the selected set
    function automatic logic [6:0] frame_bits(asfs_lanes_t sel);
        case (sel)
            LANES_0:   frame_bits = 7'(SEG_BITS);
            LANES_ALL: frame_bits = 7'(4 * SEG_BITS);
            default:   frame_bits = 7'(2 * SEG_BITS);
        endcase
    endfunction : frame_bits

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    asfs_cfg_t                  cfg_q;
    logic      [FRAC_W-1:0]     low_q;
    logic      [FRAC_W-1:0]     mod_q;
    logic      [SERDIV_W-1:0]   serdiv_q;
    logic      [FRAMES_W-1:0]   remain_q;
    logic                       unlimited_q;
    asfs_lvl_t                  qi_m_q, qi_q, qq_m_q, qq_q;
    logic      [13:0]           acc_q;
    logic      [13:0]           acc_sum;
    logic      [13:0]           denom;
    logic                       conv_en;
    logic      [SERDIV_W-1:0]   sdiv_cnt_q;
    logic                       ser_en;
    logic      [3:0]            pins_d;
    logic      [SEG_BITS-1:0]   hold_q [4];
    logic      [SEG_BITS-1:0]   sh_q   [4];
    logic      [3:0]            samp_cnt_q;
    logic                       slice_done;
    logic                       pend_q;
    logic                       ser_start;
    logic                       stream_ok;
    asfs_ser_t                  state_q;
    logic      [6:0]            pos_q;
    logic      [1:0]            cur_lane;
    logic      [3:0]            cur_bit;
    logic      [14:0]           tcnt_q;
    logic      [14:0]           tper_len;

    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------
    // configuration writes; illegal field codes fall to defaults later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q    <= CFG_RST;
            low_q    <= LOW_RST;
            mod_q    <= MOD_RST;
            serdiv_q <= SERDIV_RST;
        end else if (wr_stb) begin
            case (addr)
                ADDR_CTRL: begin
                    cfg_q.fmt   <= asfs_fmt_t'(wdata[CTRL_FMT_LSB +: 2]);
                    cfg_q.res   <= asfs_res_t'(wdata[CTRL_RES_LSB +: 3]);
                    cfg_q.lanes <= asfs_lanes_t'(wdata[CTRL_LANE_LSB +: 2]);
                    cfg_q.tper  <= wdata[CTRL_TPER_LSB +: 3];
                end
                ADDR_FRAC: begin
                    low_q <= wdata[FRAC_LOW_LSB +: FRAC_W];
                    mod_q <= wdata[FRAC_MOD_LSB +: FRAC_W];
                end
                ADDR_SERDIV: serdiv_q <= wdata[SERDIV_W-1:0];
                default: ;
            endcase
        end
    end

    // read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= '0;
            if (rd_stb) begin
                case (addr)
                    ADDR_CTRL: begin
                        rdata[CTRL_FMT_LSB +: 2]  <= cfg_q.fmt;
                        rdata[CTRL_RES_LSB +: 3]  <= cfg_q.res;
                        rdata[CTRL_LANE_LSB +: 2] <= cfg_q.lanes;
                        rdata[CTRL_TPER_LSB +: 3] <= cfg_q.tper;
                    end
                    ADDR_FRAC: begin
                        rdata[FRAC_LOW_LSB +: FRAC_W] <= low_q;
                        rdata[FRAC_MOD_LSB +: FRAC_W] <= mod_q;
                    end
                    ADDR_SERDIV: rdata[SERDIV_W-1:0] <= serdiv_q;
                    ADDR_STREAM: rdata[FRAMES_W-1:0] <= remain_q;
                    ADDR_STATUS: begin
                        rdata[STAT_ACT_BIT]         <= (state_q == SER_SHIFT);
                        rdata[STAT_CNT_LSB +: 4]    <= samp_cnt_q;
                        rdata[STAT_REM_LSB +: FRAMES_W] <= remain_q;
                    end
                    default: rdata <= '0;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // quantizer input synchronisers
    // ---------------------------------------------------------------
    // the quantizer is outside our clock, so two stages first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qi_m_q <= '0;
            qi_q   <= '0;
            qq_m_q <= '0;
            qq_q   <= '0;
        end else begin
            qi_m_q <= quant_i;
            qi_q   <= qi_m_q;
            qq_m_q <= quant_q;
            qq_q   <= qq_m_q;
        end
    end

    // ---------------------------------------------------------------
    // fractional divider for the converter rate
    // ---------------------------------------------------------------
    // phase accumulator: add low each cycle, wrap at the denominator
    assign denom   = FRAC_MODULUS - 14'(mod_q) + 14'(low_q);
    assign acc_sum = acc_q + 14'(low_q);
    assign conv_en = conv_strobe;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q       <= '0;
            conv_strobe <= 1'b0;
        end else if (denom == '0 || low_q == '0) begin
            acc_q       <= '0;                           // divider parked
            conv_strobe <= 1'b0;
        end else if (acc_sum >= denom) begin
            acc_q       <= acc_sum - denom;
            conv_strobe <= 1'b1;
        end else begin
            acc_q       <= acc_sum;
            conv_strobe <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // serial rate divider
    // ---------------------------------------------------------------
    // divide value n gives one serial cycle every n+1 clocks
    assign ser_en = serial_strobe;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdiv_cnt_q    <= '0;
            serial_strobe <= 1'b0;
        end else if (sdiv_cnt_q >= serdiv_q) begin
            sdiv_cnt_q    <= '0;
            serial_strobe <= 1'b1;
        end else begin
            sdiv_cnt_q    <= sdiv_cnt_q + 1'b1;
            serial_strobe <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // output pins and holding registers
    // ---------------------------------------------------------------
    assign pins_d     = pin_map(cfg_q, qi_q, qq_q);
    assign slice_done = conv_en && (samp_cnt_q == 4'hF);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inphase_upper_pin    <= 1'b0;
            inphase_lower_pin    <= 1'b0;
            quadrature_upper_pin <= 1'b0;
            quadrature_lower_pin <= 1'b0;
        end else if (conv_en) begin
            inphase_upper_pin    <= pins_d[3];
            inphase_lower_pin    <= pins_d[2];
            quadrature_upper_pin <= pins_d[1];
            quadrature_lower_pin <= pins_d[0];
        end
    end

    // lane 0 = i upper ... lane 3 = q lower; newest bit enters at lsb
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            samp_cnt_q <= '0;
            for (int k = 0; k < 4; k++) begin
                hold_q[k] <= '0;
                sh_q[k]   <= '0;
            end
        end else if (conv_en) begin
            samp_cnt_q <= samp_cnt_q + 1'b1;
            for (int k = 0; k < 4; k++) begin
                hold_q[k] <= {hold_q[k][SEG_BITS-2:0], pins_d[3-k]};
                if (slice_done) begin
                    sh_q[k] <= {hold_q[k][SEG_BITS-2:0], pins_d[3-k]};
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // slice hand-off and frame budget
    // ---------------------------------------------------------------
    assign stream_ok = unlimited_q || (remain_q != '0);
    assign ser_start = ser_en && pend_q && stream_ok;

    // a new slice arriving as the old one is taken keeps the flag set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_q <= 1'b0;
        end else if (slice_done) begin
            pend_q <= 1'b1;
        end else if (ser_en) begin
            pend_q <= 1'b0;
        end
    end

    // writing zero streams forever, a count sends that many slices
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain_q    <= '0;
            unlimited_q <= 1'b1;
        end else if (wr_stb && addr == ADDR_STREAM) begin
            remain_q    <= wdata[FRAMES_W-1:0];
            unlimited_q <= (wdata[FRAMES_W-1:0] == '0);
        end else if (ser_start && !unlimited_q) begin
            remain_q    <= remain_q - 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // serializer
    // ---------------------------------------------------------------
    // a late slice restarts the frame: too slow a serial rate loses data
    assign cur_lane = lane_of(cfg_q.lanes, pos_q[5:4]);
    assign cur_bit  = pos_q[3:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q            <= SER_IDLE;
            pos_q              <= '0;
            serial_data        <= 1'b0;
            slice_start_strobe <= 1'b0;
        end else if (ser_start) begin
            state_q            <= SER_SHIFT;
            pos_q              <= 7'h01;
            serial_data        <= sh_q[0][SEG_BITS-1];
            slice_start_strobe <= 1'b1;
        end else if (ser_en) begin
            slice_start_strobe <= 1'b0;
            case (state_q)
                SER_SHIFT: begin
                    if (pos_q == frame_bits(cfg_q.lanes)) begin
                        state_q     <= SER_IDLE;
                        serial_data <= 1'b0;
                    end else begin
                        pos_q       <= pos_q + 1'b1;
                        serial_data <= sh_q[cur_lane][SEG_BITS-1-
                                                      int'(cur_bit)];
                    end
                end
                default: serial_data <= 1'b0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // timing strobe
    // ---------------------------------------------------------------
    assign tper_len = TSYNC_BASE << cfg_q.tper;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tcnt_q      <= '0;
            time_strobe <= 1'b0;
        end else if (conv_en && tcnt_q >= tper_len - 1'b1) begin
            tcnt_q      <= '0;
            time_strobe <= 1'b1;
        end else begin
            tcnt_q      <= conv_en ? tcnt_q + 1'b1 : tcnt_q;
            time_strobe <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_time_on_conv: assert property (
        time_strobe |-> $past(conv_en))
        else $error("timing strobe without converter cycle");
    // bound taken from the cycle of the update; a rewrite trips it only when acc_q holds twice the new denom or more
    a_frac_acc_bound: assert property (
        denom != '0 |=> acc_q < $past(denom + 14'(low_q)))
        else $error("fractional accumulator out of range");
    a_start_one_bit: assert property (
        slice_start_strobe |-> state_q == SER_SHIFT && pos_q == 7'h01)
        else $error("slice strobe not on first bit");
    a_start_one_cyc: assert property (
        slice_start_strobe && ser_en && !pend_q |=> !slice_start_strobe)
        else $error("slice strobe longer than a serial cycle");
    a_idle_zero: assert property (
        $past(ser_en && state_q == SER_IDLE && !ser_start)
        |-> !serial_data)
        else $error("serial data not zero while idle");
    a_pend_set_wins: assert property (
        slice_done |=> pend_q)
        else $error("slice hand-off lost");
    a_frame_stop: assert property (
        !unlimited_q && remain_q == '0 |-> !ser_start)
        else $error("slice sent past frame budget");
    a_ob_sign_pin: assert property (
        $past(conv_en && cfg_q.fmt == FMT_OFFSET)
        |-> inphase_upper_pin == !$past(qi_q.neg))
        else $error("offset binary msb wrong");
    a_sm_sign_pin: assert property (
        $past(conv_en && cfg_q.fmt != FMT_OFFSET)
        |-> inphase_upper_pin == $past(qi_q.neg))
        else $error("sign bit wrong");
    a_i3_q_low: assert property (
        $past(conv_en && cfg_q.res == RES_I3) |-> !quadrature_lower_pin)
        else $error("q lower pin active in 3-bit mode");

    c_four_lane: cover property (ser_start && cfg_q.lanes == LANES_ALL);
    c_time_pulse: cover property (time_strobe);
    c_three_bit: cover property (conv_en && cfg_q.res == RES_I3);

endmodule : asfs_top

// >>> verilog/asfs_pkg.sv
// shared constants and types for the sample formatter and serializer
package asfs_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam int           ADDR_W      = 8;
    localparam int           DATA_W      = 32;
    localparam logic [7:0]   ADDR_CTRL   = 8'h00;
    localparam logic [7:0]   ADDR_FRAC   = 8'h04;
    localparam logic [7:0]   ADDR_SERDIV = 8'h08;
    localparam logic [7:0]   ADDR_STREAM = 8'h0C;
    localparam logic [7:0]   ADDR_STATUS = 8'h10;

    // ---------------------------------------------------------------
    // field positions and widths
    // ---------------------------------------------------------------
    localparam int           CTRL_FMT_LSB  = 0;
    localparam int           CTRL_RES_LSB  = 2;
    localparam int           CTRL_LANE_LSB = 5;
    localparam int           CTRL_TPER_LSB = 7;
    localparam int           FRAC_LOW_LSB  = 0;
    localparam int           FRAC_MOD_LSB  = 16;
    localparam int           FRAC_W        = 12;
    localparam logic [13:0]  FRAC_MODULUS  = 14'h1000;
    localparam int           SERDIV_W      = 8;
    localparam int           FRAMES_W      = 16;
    localparam int           SEG_BITS      = 16;
    localparam logic [14:0]  TSYNC_BASE    = 15'h0080;
    localparam int           STAT_ACT_BIT  = 0;
    localparam int           STAT_CNT_LSB  = 4;
    localparam int           STAT_REM_LSB  = 16;

    // ---------------------------------------------------------------
    // modes and states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {FMT_OFFSET, FMT_SIGNMAG, FMT_TWOS} asfs_fmt_t;
    typedef enum logic [2:0] {RES_IQ1, RES_IQ2, RES_I1, RES_I2, RES_I3}
        asfs_res_t;
    typedef enum logic [1:0] {LANES_0, LANES_01, LANES_02, LANES_ALL}
        asfs_lanes_t;
    typedef enum logic {SER_IDLE, SER_SHIFT} asfs_ser_t;

    typedef struct packed {
        logic [2:0]  tper;
        asfs_lanes_t lanes;
        asfs_res_t   res;
        asfs_fmt_t   fmt;
    } asfs_cfg_t;

    // quantizer level: neg=1 below zero, mag 0..3 stands for 1,3,5,7
    typedef struct packed {
        logic       neg;
        logic [1:0] mag;
    } asfs_lvl_t;

    localparam asfs_cfg_t CFG_RST = '{tper: 3'h0, lanes: LANES_0,
                                      res: RES_IQ2, fmt: FMT_SIGNMAG};

endpackage : asfs_pkg

// >>> test/asfs_dsp_model.sv
// baseband-side capture model for the serial sample stream
`timescale 1ns/1ps
module asfs_dsp_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_strobe,
    input wire logic serial_data,
    input wire logic slice_start_strobe
);
    logic bits[$];
    int   starts;
    // one bit per serial cycle; a slice start drops the older bits
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            starts = 0;
            bits.delete();
        end else if (serial_strobe) begin
            if (slice_start_strobe) begin
                starts++;
                bits.delete();
            end
            bits.push_back(serial_data);
        end
    end
endmodule : asfs_dsp_model

// >>> test/tb_asfs_top.sv
// self-checking bench for the sample formatter and serializer
`timescale 1ns/1ps
module tb_asfs_top;
    import asfs_pkg::*;
    logic clk, rst, wr_stb, rd_stb, inphase_upper_pin, inphase_lower_pin;
    logic quadrature_upper_pin, quadrature_lower_pin, conv_strobe;
    logic serial_strobe, serial_data, slice_start_strobe, time_strobe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    asfs_lvl_t         quant_i, quant_q;
    int err_count, check_count, ccnt, c, n, e;
    logic [7:0]  ra[5] = '{ADDR_CTRL, ADDR_FRAC, ADDR_SERDIV, ADDR_STREAM,
                           8'h14};
    logic [31:0] rv[5] = '{32'(CFG_RST), 32'h0E00_0100, 32'h0, 32'h0, 32'h0};
    logic [31:0] fr[2] = '{32'h0000_0200, 32'h0100_0100};
    int          ex[2] = '{128, 72};
    asfs_top asfs_top_inst (.clk, .rst, .addr, .wdata, .wr_stb, .rd_stb,
        .rdata, .quant_i, .quant_q, .inphase_upper_pin, .inphase_lower_pin,
        .quadrature_upper_pin, .quadrature_lower_pin, .conv_strobe,
        .serial_strobe, .serial_data, .slice_start_strobe, .time_strobe);
    asfs_dsp_model asfs_dsp_model_inst (.clk, .rst, .serial_strobe,
        .serial_data, .slice_start_strobe);
    // ---------------------------------------------------------------
    // clock, converter cycle count, watchdog
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (conv_strobe === 1'b1) ccnt++;
    // whole run is near 13k cycles; a hang is cut well after that
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        complete_run();
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd
    // snapshot taken off the edge so the counter process has settled
    task automatic wait_ts(output int s);
        repeat (5000) begin
            @(posedge clk);
            if (time_strobe === 1'b1) break;
        end
        @(negedge clk);
        s = ccnt;
    endtask : wait_ts
    task automatic wait_start();
        int s0 = asfs_dsp_model_inst.starts;
        repeat (2000) begin
            @(posedge clk);
            if (asfs_dsp_model_inst.starts != s0) break;
        end
    endtask : wait_start
    function automatic logic [2:0] enc(int f, asfs_lvl_t l);
        logic [1:0] m = l.neg ? ~l.mag : l.mag;
        case (f)
            0: return {~l.neg, m};
            1: return {l.neg, l.mag};
            default: return {l.neg, m};
        endcase
    endfunction : enc
    function automatic logic [3:0] pexp(int r, logic [2:0] ci, cq);
        case (r)
            0: return {ci[2], 1'b0, cq[2], 1'b0};
            2: return {ci[2], 3'b000};
            3: return {ci[2:1], 2'b00};
            4: return {ci, 1'b0};
            default: return {ci[2:1], cq[2:1]};
        endcase
    endfunction : pexp
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {rst, wr_stb, rd_stb, addr, wdata, quant_i, quant_q} = '0;
        rst = 1'b1;
        {err_count, check_count, ccnt} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[k]) begin
            rd(ra[k], v);
            chk("reset value", v, rv[k]);
        end
        $display("register test done");
        wr(ADDR_FRAC, 32'h0800_0800);
        for (int f = 0; f < 3; f++) for (int r = 0; r < 5; r++) begin
            wr(ADDR_CTRL, {27'h0, 3'(r), 2'(f)});
            for (int l = 0; l < 8; l++) begin
                quant_i <= 3'(l);
                quant_q <= ~3'(l);
                repeat (10) @(posedge clk);
                chk("pins", {inphase_upper_pin, inphase_lower_pin,
                    quadrature_upper_pin, quadrature_lower_pin},
                    pexp(r, enc(f, 3'(l)), enc(f, ~3'(l))));
            end
        end
        $display("coding test done");
        foreach (fr[k]) begin
            wr(ADDR_FRAC, fr[k]);
            repeat (40) @(posedge clk);
            @(negedge clk) c = ccnt;
            repeat (1152) @(posedge clk);
            @(negedge clk) n = ccnt - c;
            chk("ratio", 32'(n >= ex[k] - 1 && n <= ex[k] + 1), 32'h1);
        end
        wr(ADDR_FRAC, 32'h0800_0800);
        for (int t = 0; t < 3; t++) begin
            wr(ADDR_CTRL, {22'h0, 3'(t), 7'h05});
            wait_ts(c);
            wait_ts(c);
            wait_ts(n);
            chk("time period", 32'(n - c), 32'(128 << t));
        end
        $display("timing test done");
        quant_i <= 3'b100;
        quant_q <= 3'b111;
        wr(ADDR_FRAC, 32'h0100_0100);
        wr(ADDR_SERDIV, 32'h0000_0001);
        for (int L = 0; L < 4; L++) begin
            wr(ADDR_CTRL, {25'h0, 2'(L), 5'h05});
            wait_start();
            wait_start();
            repeat (160) @(posedge clk);
            n = (L == 3) ? 4 : (L == 0) ? 1 : 2;
            for (int b = 0; b < n * 16 + 8; b++) begin
                e = (L == 3) ? b / 16 : (b < 16) ? 0 : (L == 2) ? 2 : 1;
                e = (b < n * 16) ? 32'(4'b1101 >> e) & 1 : 0;
                chk("serial", 32'(asfs_dsp_model_inst.bits[b]), 32'(e));
            end
        end
        wr(ADDR_CTRL, 32'h0000_0005);
        // load the budget just after a start so no start is in flight
        wait_start();
        wr(ADDR_STREAM, 32'h0000_0002);
        c = asfs_dsp_model_inst.starts;
        repeat (1500) @(posedge clk);
        chk("stream", 32'(asfs_dsp_model_inst.starts - c), 32'h2);
        rd(ADDR_STREAM, v);
        chk("remaining", v, 32'h0);
        $display("serial test done");
        complete_run();
    end
endmodule : tb_asfs_top
